/* File: src/bmss_pkg.sv */
// package of strap encodings, boot addresses and state types for the boot mode strap selector
package bmss_pkg;
  // primary core boot select encodings
  localparam logic [1:0] BMSS_PRI_HOST = 2'h0;
  localparam logic [1:0] BMSS_PRI_NAND = 2'h1;
  localparam logic [1:0] BMSS_PRI_UART = 2'h2;
  localparam logic [1:0] BMSS_PRI_NOR = 2'h3;
  // fixed branch addresses
  localparam logic [31:0] BMSS_NOR_ADDR = 32'h02000000;
  localparam logic [31:0] BMSS_SIG_FIXED_ADDR = 32'h42200000;
  localparam logic [31:0] BMSS_ZERO_ADDR = 32'h00000000;
  // startup source select encodings for the single-core variant
  localparam logic [3:0] BMSS_SS_NONE = 4'h0;
  localparam logic [3:0] BMSS_SS_HOST = 4'h1;
  localparam logic [3:0] BMSS_SS_EMEM = 4'h2;
  localparam logic [3:0] BMSS_SS_I2C = 4'h3;
  localparam logic [3:0] BMSS_SS_SPI = 4'h4;
  localparam logic [3:0] BMSS_SS_UART = 4'h5;
  localparam logic [3:0] BMSS_SS_EMU = 4'h6;
  // fixed pll multiplier used when fast boot uses no multiplier strap
  localparam logic [2:0] BMSS_FIXED_MULT = 3'h0;
  localparam logic [2:0] BMSS_MULT_USER_MAX = 3'h7;
  // boot source classes
  typedef enum logic [2:0] {
    BMSS_SRC_NONE = 3'h0,
    BMSS_SRC_HOST = 3'h1,
    BMSS_SRC_EMEM = 3'h2,
    BMSS_SRC_SERIAL = 3'h3,
    BMSS_SRC_NOCOPY = 3'h4,
    BMSS_SRC_EMU = 3'h5
  } bmss_src_t;
  // sequencer states, gray coded along the main path
  typedef enum logic [2:0] {
    BMSS_ST_RESET = 3'b000,
    BMSS_ST_SAMPLE = 3'b001,
    BMSS_ST_LOAD = 3'b011,
    BMSS_ST_PRI_RUN = 3'b010,
    BMSS_ST_SIG_LOAD = 3'b110,
    BMSS_ST_SIG_RUN = 3'b111
  } bmss_state_t;
  // strap pins as one group
  typedef struct packed {
    logic dual_core;
    logic [1:0] primary_core_boot_select;
    logic ext_memory_data_width_strap;
    logic [4:0] ext_memory_address_width_strap;
    logic signal_core_boot_select;
    logic [3:0] startup_source_select;
    logic pci_port_enable_strap;
    logic [2:0] async_memory_config_strap;
    logic [2:0] boot_multiplier_select;
    logic accelerated_start_strap;
  } bmss_straps_t;
endpackage : bmss_pkg

/* File: src/bmss_boot_selector.sv */
// boot mode strap selector: strap latch and boot sequencer for both device variants
`timescale 1ns/10ps
// How it works
// - straps sampled after reset release decide the boot mode alone
// - dual-core: primary core boots first, then handles signal core boot
// - signal core has no loader; primary core or external host loads it
// - primary modes: host port, NAND, UART0, no-copy branch to 02000000h
// - host port mode waits for host load done, then branches
// - memory or serial modes fetch code, then transfer execution
// - two-bit select picks primary mode; width straps configure memory
// - primary core holds signal core in reset and releases it
// - signal host modes run code placed by primary or host after release
// - signal no-copy modes branch to 42200000h or primary-given address
// - one select pin chooses signal mode; width straps reused
// - single-core: host, memory, serial, emulation or none from straps
// - single-core: fast boot strap raises boot clock with fixed or strapped multiplier
// - single-core boot done by internal rom program
module bmss_boot_selector
  import bmss_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire bmss_straps_t strap_pins,
  input wire logic load_done,
  input wire logic sig_load_done,
  input wire logic sig_host_by_ext,
  input wire logic [31:0] sig_branch_addr_in,
  output logic boot_active,
  output logic rom_loader_run,
  output bmss_src_t boot_source,
  output logic [1:0] serial_port_sel,
  output logic [31:0] primary_entry_addr,
  output logic primary_run,
  output logic signal_core_reset_n,
  output logic [31:0] signal_entry_addr,
  output logic signal_host_ext,
  output logic emem_wide,
  output logic [4:0] emem_addr_width,
  output logic [2:0] emem_async_cfg,
  output logic pci_host_sel,
  output logic fast_boot_en,
  output logic [2:0] pll_multiplier,
  output logic boot_done
);

  bmss_straps_t strap_s1;
  bmss_straps_t strap_s2;
  logic done_s1, done_s2, sdone_s1, sdone_s2, ext_s1, ext_s2;
  bmss_straps_t strap_lat;
  bmss_state_t state;
  bmss_state_t next_state;
  logic sig_needs_load;
  logic [1:0] strap_fill;
  logic cur_dual;

  // classify a primary core select value
  function automatic bmss_src_t bmss_pri_src(input logic [1:0] sel);
    case (sel)
      BMSS_PRI_HOST: bmss_pri_src = BMSS_SRC_HOST;
      BMSS_PRI_NAND: bmss_pri_src = BMSS_SRC_EMEM;
      BMSS_PRI_UART: bmss_pri_src = BMSS_SRC_SERIAL;
      default: bmss_pri_src = BMSS_SRC_NOCOPY;
    endcase
  endfunction : bmss_pri_src

  // classify a startup source select value; unused codes mean no boot
  function automatic bmss_src_t bmss_ss_src(input logic [3:0] sel);
    case (sel)
      BMSS_SS_HOST: bmss_ss_src = BMSS_SRC_HOST;
      BMSS_SS_EMEM: bmss_ss_src = BMSS_SRC_EMEM;
      BMSS_SS_I2C, BMSS_SS_SPI, BMSS_SS_UART: bmss_ss_src = BMSS_SRC_SERIAL;
      BMSS_SS_EMU: bmss_ss_src = BMSS_SRC_EMU;
      default: bmss_ss_src = BMSS_SRC_NONE;
    endcase
  endfunction : bmss_ss_src

  // pin synchronisers, first stage read only by the second
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      strap_s1 <= '0;
      strap_s2 <= '0;
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      sdone_s1 <= 1'b0;
      sdone_s2 <= 1'b0;
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      strap_fill <= 2'h0;
    end else if (clk_en) begin
      strap_s1 <= strap_pins;
      strap_s2 <= strap_s1;
      done_s1 <= load_done;
      done_s2 <= done_s1;
      sdone_s1 <= sig_load_done;
      sdone_s2 <= sdone_s1;
      ext_s1 <= sig_host_by_ext;
      ext_s2 <= ext_s1;
      // marks the strap pipe as filled with real pin levels
      strap_fill <= {strap_fill[0], 1'b1};
    end
  end

  // strap latch once
  // captured by a clock after release, never by the reset itself
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      strap_lat <= '0;
    end else if (clk_en && state == BMSS_ST_SAMPLE) begin
      strap_lat <= strap_s2;
    end
  end

  // signal core needs a load when in a host mode (select low)
  assign sig_needs_load = !strap_lat.signal_core_boot_select;

  // variant seen this cycle; the latch is only written at the sample edge
  assign cur_dual = (state == BMSS_ST_SAMPLE) ? strap_s2.dual_core : strap_lat.dual_core;

  // sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      // wait until both sync stages hold pin levels, not reset zeros
      BMSS_ST_RESET: begin
        if (strap_fill[1]) begin
          next_state = BMSS_ST_SAMPLE;
        end
      end
      BMSS_ST_SAMPLE: next_state = BMSS_ST_LOAD;
      BMSS_ST_LOAD: begin
        if (strap_lat.dual_core && bmss_pri_src(strap_lat.primary_core_boot_select) == BMSS_SRC_NOCOPY) begin
          next_state = BMSS_ST_PRI_RUN;
        end else if (!strap_lat.dual_core && bmss_ss_src(strap_lat.startup_source_select) inside
                     {BMSS_SRC_NONE, BMSS_SRC_EMU}) begin
          next_state = BMSS_ST_PRI_RUN;
        end else if (done_s2) begin
          next_state = BMSS_ST_PRI_RUN;
        end
      end
      BMSS_ST_PRI_RUN: begin
        if (strap_lat.dual_core) begin
          next_state = BMSS_ST_SIG_LOAD;
        end
      end
      BMSS_ST_SIG_LOAD: begin
        if (!sig_needs_load || sdone_s2) begin
          next_state = BMSS_ST_SIG_RUN;
        end
      end
      BMSS_ST_SIG_RUN: next_state = BMSS_ST_SIG_RUN;
      default: next_state = BMSS_ST_RESET;
    endcase
  end

  // sequencer state register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state <= BMSS_ST_RESET;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      boot_source <= BMSS_SRC_NONE;
      serial_port_sel <= 2'h0;
      pci_host_sel <= 1'b0;
      primary_entry_addr <= BMSS_ZERO_ADDR;
    end else if (clk_en && state == BMSS_ST_SAMPLE) begin
      if (strap_s2.dual_core) begin
        boot_source <= bmss_pri_src(strap_s2.primary_core_boot_select);
        serial_port_sel <= 2'h0;
        pci_host_sel <= 1'b0;
        primary_entry_addr <= (strap_s2.primary_core_boot_select == BMSS_PRI_NOR) ? BMSS_NOR_ADDR : BMSS_ZERO_ADDR;
      end else begin
        boot_source <= bmss_ss_src(strap_s2.startup_source_select);
        // port index: 0 i2c, 1 spi, 2 uart
        serial_port_sel <= (strap_s2.startup_source_select == BMSS_SS_SPI) ? 2'h1 :
                           (strap_s2.startup_source_select == BMSS_SS_UART) ? 2'h2 : 2'h0;
        pci_host_sel <= strap_s2.pci_port_enable_strap;
        primary_entry_addr <= BMSS_ZERO_ADDR;
      end
    end
  end

  // memory width config
  // the same width straps serve both cores, so they are decoded once
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      emem_wide <= 1'b0;
      emem_addr_width <= 5'h00;
      emem_async_cfg <= 3'h0;
    end else if (clk_en && state == BMSS_ST_SAMPLE) begin
      emem_wide <= strap_s2.ext_memory_data_width_strap;
      emem_addr_width <= strap_s2.ext_memory_address_width_strap;
      emem_async_cfg <= strap_s2.async_memory_config_strap;
    end
  end

  // fast boot multiplier
  // user multiplier taken from the strap; fixed when the strap reads all ones
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fast_boot_en <= 1'b0;
      pll_multiplier <= BMSS_FIXED_MULT;
    end else if (clk_en) begin
      if (state == BMSS_ST_SAMPLE) begin
        fast_boot_en <= !strap_s2.dual_core && strap_s2.accelerated_start_strap;
        pll_multiplier <= (strap_s2.boot_multiplier_select == BMSS_MULT_USER_MAX) ? BMSS_FIXED_MULT :
                          strap_s2.boot_multiplier_select;
      end else if (next_state == BMSS_ST_PRI_RUN) begin
        // boot is over, drop the raised clock
        fast_boot_en <= 1'b0;
      end
    end
  end

  // rom loader and primary run flags
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      boot_active <= 1'b0;
      rom_loader_run <= 1'b0;
      primary_run <= 1'b0;
      boot_done <= 1'b0;
    end else if (clk_en) begin
      boot_active <= (next_state == BMSS_ST_LOAD) || (next_state == BMSS_ST_SIG_LOAD);
      rom_loader_run <= (next_state == BMSS_ST_LOAD) && !cur_dual;
      primary_run <= (next_state == BMSS_ST_PRI_RUN) || (next_state == BMSS_ST_SIG_LOAD) ||
                     (next_state == BMSS_ST_SIG_RUN);
      boot_done <= (next_state == BMSS_ST_SIG_RUN) || (next_state == BMSS_ST_PRI_RUN && !strap_lat.dual_core);
    end
  end

  // signal core reset and entry
  // the signal core has no loader of its own, so it stays held until the sequencer says so
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      signal_core_reset_n <= 1'b0;
      signal_entry_addr <= BMSS_ZERO_ADDR;
      signal_host_ext <= 1'b0;
    end else if (clk_en) begin
      signal_core_reset_n <= (next_state == BMSS_ST_SIG_RUN);
      if (state == BMSS_ST_SIG_LOAD) begin
        signal_host_ext <= sig_needs_load && ext_s2;
        if (!sig_needs_load) begin
          signal_entry_addr <= ext_s2 ? sig_branch_addr_in : BMSS_SIG_FIXED_ADDR;
        end else begin
          signal_entry_addr <= BMSS_ZERO_ADDR;
        end
      end
    end
  end

  AST_SIG_AFTER_PRI: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(signal_core_reset_n) |-> primary_run)
    else $error("signal core released before primary core runs");

  AST_STRAP_HOLD: assert property (@(posedge ref_clk) disable iff (!rstn)
    (state != BMSS_ST_SAMPLE && state != BMSS_ST_RESET) |=> $stable(strap_lat))
    else $error("latched straps changed after sampling");

  AST_NOR_ADDR: assert property (@(posedge ref_clk) disable iff (!rstn)
    (clk_en && state == BMSS_ST_SAMPLE && strap_s2.dual_core && strap_s2.primary_core_boot_select == BMSS_PRI_NOR)
    |=> primary_entry_addr == BMSS_NOR_ADDR && boot_source == BMSS_SRC_NOCOPY)
    else $error("nor no-copy address wrong");

  sequence bmss_loading;
    state == BMSS_ST_LOAD && boot_source == BMSS_SRC_HOST && !done_s2;
  endsequence
  AST_HOST_WAITS: assert property (@(posedge ref_clk) disable iff (!rstn)
    bmss_loading |=> state == BMSS_ST_LOAD)
    else $error("host boot left load before done");

  // signal core held during primary load
  AST_SIG_HELD: assert property (@(posedge ref_clk) disable iff (!rstn)
    (state == BMSS_ST_LOAD) |-> !signal_core_reset_n)
    else $error("signal core out of reset during primary load");

  AST_SIG_FIXED: assert property (@(posedge ref_clk) disable iff (!rstn)
    (clk_en && state == BMSS_ST_SIG_LOAD && !sig_needs_load && !ext_s2)
    |=> signal_entry_addr == BMSS_SIG_FIXED_ADDR)
    else $error("signal core fixed address wrong");

  // rom loader only on single core
  AST_ROM_SINGLE: assert property (@(posedge ref_clk) disable iff (!rstn)
    rom_loader_run |-> !strap_lat.dual_core)
    else $error("rom loader ran on dual-core variant");

  AST_FAST_BOOT: assert property (@(posedge ref_clk) disable iff (!rstn)
    (state == BMSS_ST_SIG_RUN) |-> !fast_boot_en)
    else $error("fast boot clock left raised after boot");

  AST_SIG_LOAD_FIRST: assert property (@(posedge ref_clk) disable iff (!rstn)
    (clk_en && state == BMSS_ST_SIG_LOAD && sig_needs_load && !sdone_s2) |=> !signal_core_reset_n)
    else $error("signal core released before load done");

endmodule : bmss_boot_selector

/* File: bench/bmss_far_side.sv */
// far-side boot source model: host, flash or serial source answering after a delay
`timescale 1ns/10ps
module bmss_far_side (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic boot_active,
  input wire logic primary_run,
  input wire logic [3:0] delay,
  output logic load_done,
  output logic sig_load_done
);
  logic [3:0] cnt;
  // load ends after a set delay; done drops once the device stops loading
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 4'h0;
      load_done <= 1'b0;
      sig_load_done <= 1'b0;
    end else if (!boot_active) begin
      cnt <= 4'h0;
      load_done <= 1'b0;
      sig_load_done <= 1'b0;
    end else if (cnt != delay) begin
      cnt <= cnt + 4'h1;
    end else if (primary_run) begin
      sig_load_done <= 1'b1;
    end else begin
      load_done <= 1'b1;
    end
  end
endmodule : bmss_far_side

/* File: bench/bmss_boot_selector_tb.sv */
// self-checking bench for the boot mode strap selector against a reference model
`timescale 1ns/10ps
module bmss_boot_selector_tb;
  import bmss_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  bmss_straps_t strap_pins = '0;
  bmss_straps_t s;
  logic sig_host_by_ext = 1'b0;
  logic [31:0] sig_branch_addr_in = 32'h0;
  logic [3:0] delay = 4'h2;
  logic load_done, sig_load_done, boot_active, rom_loader_run, primary_run, signal_core_reset_n;
  logic signal_host_ext, emem_wide, pci_host_sel, fast_boot_en, boot_done;
  bmss_src_t boot_source;
  logic [1:0] serial_port_sel;
  logic [31:0] primary_entry_addr, signal_entry_addr, r;
  logic [4:0] emem_addr_width;
  logic [2:0] emem_async_cfg, pll_multiplier;
  int num_errors = 0;
  int compares = 0;
  int exp[12];
  int n;
  bmss_boot_selector i_bmss_boot_selector (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en),
    .strap_pins(strap_pins), .load_done(load_done), .sig_load_done(sig_load_done),
    .sig_host_by_ext(sig_host_by_ext), .sig_branch_addr_in(sig_branch_addr_in),
    .boot_active(boot_active), .rom_loader_run(rom_loader_run), .boot_source(boot_source),
    .serial_port_sel(serial_port_sel), .primary_entry_addr(primary_entry_addr),
    .primary_run(primary_run), .signal_core_reset_n(signal_core_reset_n),
    .signal_entry_addr(signal_entry_addr), .signal_host_ext(signal_host_ext), .emem_wide(emem_wide),
    .emem_addr_width(emem_addr_width), .emem_async_cfg(emem_async_cfg), .pci_host_sel(pci_host_sel),
    .fast_boot_en(fast_boot_en), .pll_multiplier(pll_multiplier), .boot_done(boot_done));
  bmss_far_side i_bmss_far_side (.ref_clk(ref_clk), .rstn(rstn), .boot_active(boot_active),
    .primary_run(primary_run), .delay(delay), .load_done(load_done), .sig_load_done(sig_load_done));
  // 50 mhz clock
  always #10 ref_clk = ~ref_clk;
  // galois lfsr, never reaches zero from a nonzero seed
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h04c11db7 : 32'h0);
  endfunction : nxt
  task check_val(input logic [31:0] got, input logic [31:0] want, input string what);
    compares++;
    if (got !== want) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask : check_val
  task final_report;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  // compare the decoded results with the model; the multiplier only on single core, fast_boot_en not here
  task check_all;
    logic [31:0] got[12];
    got = '{32'(boot_source), 32'(serial_port_sel), primary_entry_addr, signal_entry_addr,
      32'(signal_host_ext), 32'(emem_wide), 32'(emem_addr_width), 32'(emem_async_cfg),
      32'(pci_host_sel), 32'(boot_done), 32'(primary_run), 32'(signal_core_reset_n)};
    for (int i = 0; i < 12; i++) check_val(got[i], exp[i], "decoded output");
    if (!s.dual_core) check_val(32'(pll_multiplier), (s.boot_multiplier_select == 3'h7) ?
      32'(BMSS_FIXED_MULT) : 32'(s.boot_multiplier_select), "multiplier");
  endtask : check_all
  // the wait is bounded well above the longest load so a hang cannot stall the run
  initial begin
    #400000;
    num_errors++;
    final_report();
  end
  initial begin
    r = 32'h8cf4fba8;
    for (int t = 0; t < 40; t++) begin
      @(negedge ref_clk);
      r = nxt(r);
      rstn <= 1'b0;
      s = bmss_straps_t'(r[21:0]);
      s.dual_core = t[0];
      s.primary_core_boot_select = t[2:1];
      s.signal_core_boot_select = t[3];
      if (!t[0]) s.startup_source_select = 4'(t / 2);
      strap_pins <= s;
      sig_host_by_ext <= r[31];
      sig_branch_addr_in <= nxt(r);
      delay <= r[27:24];
      repeat (12) @(negedge ref_clk);
      check_val(32'({boot_active, primary_run, signal_core_reset_n}), 0, "reset outputs");
      rstn <= 1'b1;
      // reference model of the strap decode
      exp = '{default: 0};
      exp[5] = s.ext_memory_data_width_strap;
      exp[6] = s.ext_memory_address_width_strap;
      exp[7] = s.async_memory_config_strap;
      exp[9] = 1;
      exp[10] = 1;
      exp[11] = s.dual_core;
      if (s.dual_core) begin
        exp[0] = s.primary_core_boot_select + 1;
        exp[2] = (s.primary_core_boot_select == 2'h3) ? BMSS_NOR_ADDR : 0;
        if (s.signal_core_boot_select) exp[3] = r[31] ? nxt(r) : BMSS_SIG_FIXED_ADDR;
        exp[4] = !s.signal_core_boot_select && r[31];
      end else begin
        n = s.startup_source_select;
        exp[0] = (n < 3) ? n : (n < 6) ? 3 : (n == 6) ? 5 : 0;
        exp[1] = (n >= 3 && n < 6) ? n - 3 : 0;
        exp[8] = s.pci_port_enable_strap;
      end
      for (n = 0; n < 300 && boot_done !== 1'b1; n++) begin
        @(negedge ref_clk);
        r = nxt(r);
        clk_en <= (r[1:0] != 2'h0);
        check_val(32'(signal_core_reset_n & ~primary_run), 0, "early signal core release");
        check_val(32'(rom_loader_run), 32'(boot_active & ~s.dual_core & ~primary_run), "rom run");
        if (boot_active | primary_run) check_val(32'(fast_boot_en),
          32'(boot_active & ~primary_run & ~s.dual_core & s.accelerated_start_strap), "fast boot");
      end
      check_val(32'(n < 300), 1, "boot finished");
      check_all();
      // later strap changes must be ignored
      r = nxt(r);
      strap_pins <= bmss_straps_t'(r[21:0]);
      sig_host_by_ext <= ~sig_host_by_ext;
      repeat (6) @(negedge ref_clk);
      check_all();
    end
    final_report();
  end
endmodule : bmss_boot_selector_tb
